// ### pkg/pcint_pkg.sv
`default_nettype none
package pcint_pkg;
	// ************************************************
	// Register map (byte addresses, one word each)
	// ************************************************
	localparam logic [7:0] ADDR_PA_RISE = 8'h00;
	localparam logic [7:0] ADDR_PA_FALL = 8'h04;
	localparam logic [7:0] ADDR_PA_FLAG = 8'h08;
	localparam logic [7:0] ADDR_PB_RISE = 8'h0C;
	localparam logic [7:0] ADDR_PB_FALL = 8'h10;
	localparam logic [7:0] ADDR_PB_FLAG = 8'h14;
	localparam logic [7:0] ADDR_PC_RISE = 8'h18;
	localparam logic [7:0] ADDR_PC_FALL = 8'h1C;
	localparam logic [7:0] ADDR_PC_FLAG = 8'h20;
	localparam logic [7:0] ADDR_CTRL = 8'h24;
	// ************************************************
	// Implemented bit masks and fields
	// ************************************************
	localparam logic [7:0] MASK_PA = 8'h3F;
	localparam logic [7:0] MASK_PB_LARGE = 8'hF0;
	localparam logic [7:0] MASK_PC_SMALL = 8'h3F;
	localparam logic [7:0] MASK_PC_LARGE = 8'hFF;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam int CTRL_MASTER_BIT = 0;
	localparam int CTRL_SUMMARY_BIT = 1;
	localparam int CTRL_SLEEP_BIT = 2;
	// ************************************************
	// Per-port configuration carrier
	// ************************************************
	typedef struct packed {
		logic [7:0] rise;
		logic [7:0] fall;
		logic [7:0] flag;
	} pcint_port_t;
endpackage : pcint_pkg
`default_nettype wire

// ### design/pcint_top.sv
// Functional notes
// - With master enable set, an enabled edge raises the request and wakes the core.
// - An edge during sleep is flagged before the core resumes execution.
// - Port A rising enables for pins 0 to 5.
// - Port A falling enables for pins 0 to 5.
// - Port A flags set on enabled edges, stay until software clears.
// - Port B rising enables pins 4 to 7, large variant only; 3..0 absent.
// - Port B falling enables pins 4 to 7, large variant only.
// - Port B flags set on enabled edges, held until cleared.
// - Port C rising enables pins 0 to 7; 6 and 7 large variant only.
// - Port C falling enables pins 0 to 7; 6 and 7 large variant only.
// - Port C flags set on enabled edges, cleared only by writing zero.
// - Flags read/write plus hardware set; all bits reset to zero.
// - Unimplemented bits ignore writes and read zero.
// - Summary flag is OR of every pin flag.
// - Edge during a clearing write leaves the flag set.
// - Detection continues with master enable clear; only request and wake suppressed.
// - Both enables set flag edges of either polarity.
`default_nettype none
module pcint_top #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port pins
	input wire logic [7:0] porta_pin,
	input wire logic [7:0] portb_pin,
	input wire logic [7:0] portc_pin,
	// Core side
	input wire logic core_sleeping,
	output logic change_irq,
	output logic core_wake
);
	// ************************************************
	// Decode helpers
	// ************************************************
	function automatic logic [3:0] pcint_decode(input logic [7:0] addr);
		case (addr)
			pcint_pkg::ADDR_PA_RISE: pcint_decode = 4'h0;
			pcint_pkg::ADDR_PA_FALL: pcint_decode = 4'h1;
			pcint_pkg::ADDR_PA_FLAG: pcint_decode = 4'h2;
			pcint_pkg::ADDR_PB_RISE: pcint_decode = 4'h3;
			pcint_pkg::ADDR_PB_FALL: pcint_decode = 4'h4;
			pcint_pkg::ADDR_PB_FLAG: pcint_decode = 4'h5;
			pcint_pkg::ADDR_PC_RISE: pcint_decode = 4'h6;
			pcint_pkg::ADDR_PC_FALL: pcint_decode = 4'h7;
			pcint_pkg::ADDR_PC_FLAG: pcint_decode = 4'h8;
			pcint_pkg::ADDR_CTRL: pcint_decode = 4'h9;
			default: pcint_decode = 4'hF;
		endcase
	endfunction : pcint_decode

	localparam logic [7:0] MASK_PB = LARGE_VARIANT ? pcint_pkg::MASK_PB_LARGE : 8'h00;
	localparam logic [7:0] MASK_PC = LARGE_VARIANT ? pcint_pkg::MASK_PC_LARGE : pcint_pkg::MASK_PC_SMALL;

	logic [3:0] sel;
	logic wr_en;
	logic rd_en;
	assign sel = pcint_decode(paddr);
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite && !pready;

	// ************************************************
	// Pin sampling and edge detection
	// ************************************************
	logic [23:0] pin_sync1_reg;
	logic [23:0] pin_sync2_reg;
	logic [23:0] pin_prev_reg;
	logic [23:0] rise_det;
	logic [23:0] fall_det;
	logic [23:0] set_req;
	logic [23:0] imp_mask;
	pcint_pkg::pcint_port_t [2:0] port;
	logic [2:0][7:0] rise_reg;
	logic [2:0][7:0] fall_reg;
	logic [2:0][7:0] flag_reg;

	assign imp_mask = {MASK_PC, MASK_PB, pcint_pkg::MASK_PA};

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_sync1_reg <= 24'h000000;
			pin_sync2_reg <= 24'h000000;
			pin_prev_reg <= 24'h000000;
		end
		else
		begin
			pin_sync1_reg <= {portc_pin, portb_pin, porta_pin};
			pin_sync2_reg <= pin_sync1_reg;
			pin_prev_reg <= pin_sync2_reg;
		end
	end

	// First sample after reset equals reset value; a pin held high reads as one rising edge
	assign rise_det = pin_sync2_reg & ~pin_prev_reg;
	assign fall_det = ~pin_sync2_reg & pin_prev_reg;

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++)
		begin : g_port
			// Carrier is assembled from separate banks so each bank has a single writer
			assign port[gp] = {rise_reg[gp], fall_reg[gp], flag_reg[gp]};
			// Either enable arms its own polarity; both together catch any edge
			assign set_req[gp*8 +: 8] = ((rise_det[gp*8 +: 8] & port[gp].rise) |
				(fall_det[gp*8 +: 8] & port[gp].fall)) & imp_mask[gp*8 +: 8];
		end
	endgenerate

	// ************************************************
	// Enable registers
	// ************************************************
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 3; i++)
			begin
				rise_reg[i] <= pcint_pkg::RESET_VAL;
				fall_reg[i] <= pcint_pkg::RESET_VAL;
			end
		end
		else if (wr_en)
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (sel == 4'(3*i))
					rise_reg[i] <= pwdata[7:0] & imp_mask[i*8 +: 8];
				if (sel == 4'(3*i + 1))
					fall_reg[i] <= pwdata[7:0] & imp_mask[i*8 +: 8];
			end
		end
	end

	// ************************************************
	// Flag registers
	// ************************************************
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 3; i++)
				flag_reg[i] <= pcint_pkg::RESET_VAL;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				// Hardware set wins over a clearing write in the same cycle
				if (wr_en && sel == 4'(3*i + 2))
					flag_reg[i] <= (pwdata[7:0] | set_req[i*8 +: 8]) & imp_mask[i*8 +: 8];
				else
					flag_reg[i] <= flag_reg[i] | set_req[i*8 +: 8];
			end
		end
	end

	// ************************************************
	// Master enable, summary, request and wake
	// ************************************************
	logic master_en_reg;
	logic summary;
	assign summary = |{port[2].flag, port[1].flag, port[0].flag};

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			master_en_reg <= 1'b0;
		else if (wr_en && sel == 4'h9)
			master_en_reg <= pwdata[pcint_pkg::CTRL_MASTER_BIT];
	end

	// Request follows flags registered once; flags already hold before wake is seen
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			change_irq <= 1'b0;
			core_wake <= 1'b0;
		end
		else
		begin
			change_irq <= master_en_reg && summary;
			core_wake <= master_en_reg && summary && core_sleeping;
		end
	end

	// ************************************************
	// APB read path
	// ************************************************
	logic [7:0] rd_byte;
	always_comb
	begin
		case (sel)
			4'h0: rd_byte = port[0].rise;
			4'h1: rd_byte = port[0].fall;
			4'h2: rd_byte = port[0].flag;
			4'h3: rd_byte = port[1].rise;
			4'h4: rd_byte = port[1].fall;
			4'h5: rd_byte = port[1].flag;
			4'h6: rd_byte = port[2].rise;
			4'h7: rd_byte = port[2].fall;
			4'h8: rd_byte = port[2].flag;
			4'h9: rd_byte = {5'h00, core_sleeping, summary, master_en_reg};
			default: rd_byte = 8'h00;
		endcase
	end

	// One wait state: access phase cycle 1 answers, cycle 2 completes
	// Writes land at the completing edge, one edge after pready rises
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && sel == 4'hF;
			if (rd_en)
				prdata <= {24'h000000, rd_byte};
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	property p_edge_flags;
		@(posedge sys_clk) disable iff (!rstn)
		set_req[0] |=> port[0].flag[0];
	endproperty
	a_edge_flags: assert property (p_edge_flags) else $error("edge did not set flag");

	property p_flag_holds;
		@(posedge sys_clk) disable iff (!rstn)
		port[2].flag[3] && !(wr_en && sel == 4'h8) |=> port[2].flag[3];
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag lost without clear");

	property p_set_beats_clear;
		@(posedge sys_clk) disable iff (!rstn)
		wr_en && sel == 4'h2 && set_req[1] |=> port[0].flag[1];
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat set");

	property p_unimpl_zero;
		@(posedge sys_clk) disable iff (!rstn)
		1'b1 |-> (port[0].rise[7:6] == 2'b00) && (port[1].fall[3:0] == 4'h0) && (port[0].flag[7:6] == 2'b00);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

	property p_irq_gated;
		@(posedge sys_clk) disable iff (!rstn)
		change_irq |-> $past(master_en_reg) && $past(summary);
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("request without enable");

	property p_irq_follows;
		@(posedge sys_clk) disable iff (!rstn)
		master_en_reg && summary |=> change_irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("request missing");

	property p_single_detect;
		@(posedge sys_clk) disable iff (!rstn)
		rise_det[0] |=> !rise_det[0];
	endproperty
	a_single_detect: assert property (p_single_detect) else $error("edge detected twice");

	property p_pin_to_flag;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(porta_pin[2]) && port[0].rise[2] ##1 port[0].rise[2] ##1 port[0].rise[2]
			|=> ##1 port[0].flag[2];
	endproperty
	a_pin_to_flag: assert property (p_pin_to_flag) else $error("pin edge not flagged");

	property p_wake_after_flag;
		@(posedge sys_clk) disable iff (!rstn)
		core_wake |-> summary || $past(summary);
	endproperty
	a_wake_after_flag: assert property (p_wake_after_flag) else $error("wake before flag");

	property p_rise_write;
		@(posedge sys_clk) disable iff (!rstn)
		wr_en && sel == 4'h0 |=> port[0].rise == ($past(pwdata[7:0]) & pcint_pkg::MASK_PA);
	endproperty
	a_rise_write: assert property (p_rise_write) else $error("rise enable write wrong");

	property p_fall_write;
		@(posedge sys_clk) disable iff (!rstn)
		wr_en && sel == 4'h1 |=> port[0].fall == ($past(pwdata[7:0]) & pcint_pkg::MASK_PA);
	endproperty
	a_fall_write: assert property (p_fall_write) else $error("fall enable write wrong");

	property p_pb_low_zero;
		@(posedge sys_clk) disable iff (!rstn)
		1'b1 |-> (port[1].rise[3:0] == 4'h0) && (port[1].flag[3:0] == 4'h0);
	endproperty
	a_pb_low_zero: assert property (p_pb_low_zero) else $error("absent port bit set");

	property p_pb_fall_flag;
		@(posedge sys_clk) disable iff (!rstn)
		fall_det[12] && port[1].fall[4] |=> port[1].flag[4];
	endproperty
	a_pb_fall_flag: assert property (p_pb_fall_flag) else $error("falling edge not flagged");

	property p_pc_fall_flag;
		@(posedge sys_clk) disable iff (!rstn)
		fall_det[23] && port[2].fall[7] |=> port[2].flag[7];
	endproperty
	a_pc_fall_flag: assert property (p_pc_fall_flag) else $error("falling edge not flagged");

	property p_no_spurious_flag;
		@(posedge sys_clk) disable iff (!rstn)
		!set_req[0] && !(wr_en && sel == 4'h2) && !port[0].flag[0] |=> !port[0].flag[0];
	endproperty
	a_no_spurious_flag: assert property (p_no_spurious_flag) else $error("flag set without edge");

	property p_flag_write_clears;
		@(posedge sys_clk) disable iff (!rstn)
		wr_en && sel == 4'h8 && pwdata[7:0] == 8'h00 && set_req[23:16] == 8'h00 |=> port[2].flag == 8'h00;
	endproperty
	a_flag_write_clears: assert property (p_flag_write_clears) else $error("flag not cleared");

	property p_wake_gated;
		@(posedge sys_clk) disable iff (!rstn)
		!master_en_reg || !core_sleeping |=> !core_wake;
	endproperty
	a_wake_gated: assert property (p_wake_gated) else $error("wake without enable");
endmodule : pcint_top
`default_nettype wire

// ### tb/pcint_far.sv
`default_nettype none
module pcint_far (
	// Clock
	input wire logic sys_clk,
	// Pin levels and core state
	output logic [7:0] porta_pin,
	output logic [7:0] portb_pin,
	output logic [7:0] portc_pin,
	output logic core_sleeping
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		porta_pin = 8'h00;
		portb_pin = 8'h00;
		portc_pin = 8'h00;
		core_sleeping = 1'b0;
	end
	// Levels move just after an edge, so detection timing is repeatable
	task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic s);
		@(posedge sys_clk);
		porta_pin <= a;
		portb_pin <= b;
		portc_pin <= c;
		core_sleeping <= s;
	endtask : drive
endmodule : pcint_far
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, porta_pin, portb_pin, portc_pin;
	logic [31:0] pwdata, prdata, rd;
	logic core_sleeping, change_irq, core_wake;
	int miscompares, n_checks, n;
	logic [7:0] adr [9];
	logic [7:0] msk [3];

	pcint_top #(.LARGE_VARIANT(1'b1)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .porta_pin(porta_pin), .portb_pin(portb_pin),
		.portc_pin(portc_pin), .core_sleeping(core_sleeping), .change_irq(change_irq),
		.core_wake(core_wake));
	pcint_far i_far (.sys_clk(sys_clk), .porta_pin(porta_pin), .portb_pin(portb_pin),
		.portc_pin(portc_pin), .core_sleeping(core_sleeping));

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Request held until pready is sampled high; no latency assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		chk({31'h0, pready}, 32'h1, "pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask : rdchk

	task automatic summarize();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	initial
	begin
		#400us;
		miscompares++;
		$display("unexpected at %0t: watchdog", $time);
		summarize();
	end

	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		adr = '{pcint_pkg::ADDR_PA_RISE, pcint_pkg::ADDR_PA_FALL, pcint_pkg::ADDR_PA_FLAG,
			pcint_pkg::ADDR_PB_RISE, pcint_pkg::ADDR_PB_FALL, pcint_pkg::ADDR_PB_FLAG,
			pcint_pkg::ADDR_PC_RISE, pcint_pkg::ADDR_PC_FALL, pcint_pkg::ADDR_PC_FLAG};
		msk = '{pcint_pkg::MASK_PA, pcint_pkg::MASK_PB_LARGE, pcint_pkg::MASK_PC_LARGE};
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rdchk(adr[i], 32'h0, "reset");
		rdchk(pcint_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
		$display("test reset done");
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b1, adr[i], 32'hFFFFFFFF);
			rdchk(adr[i], {24'h0, msk[i / 3]}, "mask");
			apb(1'b1, adr[i], 32'h0);
			rdchk(adr[i], 32'h0, "clear");
		end
		apb(1'b1, 8'h28, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1, "unmapped wr");
		rdchk(8'h28, 32'h0, "unmapped rd");
		chk({31'h0, err}, 32'h1, "unmapped rd err");
		$display("test registers done");
		apb(1'b1, pcint_pkg::ADDR_PA_RISE, 32'h3F);
		apb(1'b1, pcint_pkg::ADDR_PB_RISE, 32'hF0);
		apb(1'b1, pcint_pkg::ADDR_PB_FALL, 32'hF0);
		apb(1'b1, pcint_pkg::ADDR_PC_FALL, 32'hFF);
		i_far.drive(8'hFF, 8'hFF, 8'hFF, 1'b0);
		repeat (6) @(posedge sys_clk);
		rdchk(pcint_pkg::ADDR_PA_FLAG, 32'h3F, "pa rise");
		rdchk(pcint_pkg::ADDR_PB_FLAG, 32'hF0, "pb rise");
		rdchk(pcint_pkg::ADDR_PC_FLAG, 32'h0, "pc no rise");
		@(negedge sys_clk);
		chk({31'h0, change_irq}, 32'h0, "irq masked");
		rdchk(pcint_pkg::ADDR_CTRL, 32'h2, "summary");
		for (int i = 2; i < 9; i += 3)
			apb(1'b1, adr[i], 32'h0);
		i_far.drive(8'h00, 8'h00, 8'h00, 1'b0);
		repeat (6) @(posedge sys_clk);
		rdchk(pcint_pkg::ADDR_PA_FLAG, 32'h0, "pa no fall");
		rdchk(pcint_pkg::ADDR_PB_FLAG, 32'hF0, "pb both");
		rdchk(pcint_pkg::ADDR_PC_FLAG, 32'hFF, "pc fall");
		$display("test edges done");
		apb(1'b1, pcint_pkg::ADDR_CTRL, 32'h1);
		i_far.drive(8'h00, 8'h00, 8'h00, 1'b1);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({31'h0, change_irq}, 32'h1, "irq");
		chk({31'h0, core_wake}, 32'h1, "wake");
		rdchk(pcint_pkg::ADDR_CTRL, 32'h7, "ctrl");
		apb(1'b1, pcint_pkg::ADDR_PB_FLAG, 32'h0);
		apb(1'b1, pcint_pkg::ADDR_PC_FLAG, 32'h0);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({31'h0, change_irq}, 32'h0, "irq off");
		chk({31'h0, core_wake}, 32'h0, "wake off");
		i_far.drive(8'h01, 8'h00, 8'h00, 1'b1);
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (core_wake !== 1'b1 && n < 12);
		chk({31'h0, core_wake}, 32'h1, "sleep wake");
		rdchk(pcint_pkg::ADDR_PA_FLAG, 32'h01, "sleep flag");
		$display("test sleep done");
		// Pin edge launched with the clearing write so the set lands on or after it
		fork
			i_far.drive(8'h03, 8'h00, 8'h00, 1'b0);
			apb(1'b1, pcint_pkg::ADDR_PA_FLAG, 32'h0);
		join
		repeat (4) @(posedge sys_clk);
		rdchk(pcint_pkg::ADDR_PA_FLAG, 32'h02, "set wins");
		$display("test clear race done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
